// File: design/trig_pkg.sv
// Purpose: constants and types for the capture trigger sequencer
// Assumes: one sampling clock; configuration registers reached over APB
// Notes:   register map offsets are byte addresses of 32-bit words
// Summary of operation
// (R1) basic condition is AND of all pattern matches
// (R2) one to ten sequential levels, each own condition
// (R3) levels evaluated in order; last one triggers
// (R4) later segments trigger on final level only
// (R5) external trigger acts as level zero
// (R6) internal levels wait for external stage
// (R7) bus compare: lt, le, eq, gt, ge
// (R8) bitwise or, xor, edge/level detect operators
// (R9) both flows with segmented or plain buffer
// (R10) each level has its own disable bit
// (R11) state expressions use conditions, counters, flags
// (R12) true branch may trigger, update resources, jump
// (R13) state changes only by current state branches
// (R14) trigger applies to segment or whole buffer
// (R15) trigger waits post-count samples before stopping
// (R16) counters inc/dec, flags set/clear, reusable later
// (R17) pattern: dont care, low, high, fall, rise, either
// (R18) bus patterns have per-bit dont care mask
// (R19) up to twenty counters and flags, initial values
// (R20) first true branch wins; its actions concurrent
// (R21) start loads initial state, counters and flags
// (R22) edges compare current with previous sample; probe b bit 0 is compared with a fixed 0
package trig_pkg;
  localparam int           NUM_LEVELS   = 10;
  localparam int           NUM_RES      = 20;
  localparam int           NUM_STATES   = 4;
  localparam int           NUM_BRANCH   = 3;
  localparam int           CNT_W        = 16;
  // register map
  localparam logic [11:0]  A_CTRL       = 12'h000;
  localparam logic [11:0]  A_STATUS     = 12'h004;
  localparam logic [11:0]  A_NLEVELS    = 12'h008;
  localparam logic [11:0]  A_LVL_DIS    = 12'h00c;
  localparam logic [11:0]  A_POST_CNT   = 12'h010;
  localparam logic [11:0]  A_NSEG       = 12'h014;
  localparam logic [11:0]  A_FLAG_INIT  = 12'h018;
  localparam logic [11:0]  A_FLAGS      = 12'h01c;
  localparam logic [11:0]  A_STATE      = 12'h020;
  localparam logic [11:0]  A_LVL_BASE   = 12'h100; // 4 words per level
  localparam logic [11:0]  A_CNT_BASE   = 12'h200; // counter initial values on write, live counters on read
  localparam logic [11:0]  A_BR_BASE    = 12'h300; // 2 words per state branch
  // ctrl bits
  localparam int           C_ARM        = 0;
  localparam int           C_FLOW       = 1;  // 0 sequential, 1 state based
  localparam int           C_EXT_EN     = 2;
  localparam int           C_SEG_EN     = 3;
  localparam int           C_ABORT      = 4;
  // level word 0 fields
  localparam int           L_ADV        = 31; // advanced operator in use
  localparam int           L_OP_LSB     = 0;  // 3-bit operator
  localparam int           L_SIG_LSB    = 4;  // 3-bit pattern for single signals
  localparam int           L_SIG_SEL    = 8;  // 4-bit signal index
  localparam int           L_OP2_LSB    = 12; // 3-bit compare applied to or/xor result

  typedef enum logic [2:0] {
    OP_LT = 3'h0, OP_LE = 3'h1, OP_EQ = 3'h2, OP_GT = 3'h3,
    OP_GE = 3'h4, OP_OR = 3'h5, OP_XOR = 3'h6, OP_EDGE = 3'h7
  } adv_op_t;

  typedef enum logic [2:0] {
    PAT_DC = 3'h0, PAT_LOW = 3'h1, PAT_HIGH = 3'h2,
    PAT_FALL = 3'h3, PAT_RISE = 3'h4, PAT_EITHER = 3'h5
  } pat_t;

  // branch word 0: cond sel [4:0], cond kind [6:5], invert [7], goto [9:8],
  //   trigger [10], res idx [15:11], res act [18:16], cmp value [31:19]
  typedef enum logic [1:0] {
    CK_ALWAYS = 2'h0, CK_LEVEL = 2'h1, CK_FLAG = 2'h2, CK_CNT_GE = 2'h3
  } cond_kind_t;

  typedef enum logic [2:0] {
    RA_NONE = 3'h0, RA_INC = 3'h1, RA_DEC = 3'h2, RA_SET = 3'h3, RA_CLR = 3'h4
  } res_act_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_RUN = 2'b01, ST_POST = 2'b11, ST_DONE = 2'b10
  } acq_state_t;
endpackage : trig_pkg

// File: design/cfg_mem.sv
// Purpose: small register-array memory for level and branch words
// Assumes: single write port, one combinational and one registered read
// Notes:   the whole array is visible to the evaluation logic
`timescale 1ns/100ps
module cfg_mem #(
  parameter int DEPTH = 64,
  parameter int AW    = 6
) (
  input  wire logic                  i_core_clk,
  input  wire logic                  i_rst,
  input  wire logic                  i_we,
  input  wire logic [AW-1:0]         i_addr,
  input  wire logic [31:0]           i_wdata,
  output logic      [31:0]           o_rdata,
  output logic      [DEPTH*32-1:0]   o_all
);
  logic [31:0] mem [DEPTH];
  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = mem[i_addr];
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 32'h0000_0000;
      for (int i = 0; i < DEPTH; i++) mem[i] <= 32'h0000_0000;
    end else begin
      o_rdata <= next_rdata;
      if (i_we) mem[i_addr] <= i_wdata;
    end
  end

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_flat
      assign o_all[g*32 +: 32] = mem[g];
    end
  endgenerate
endmodule : cfg_mem

// File: design/capture_trigger_sequencer.sv
// Purpose: trigger evaluation, sequential levels and state-based flow
// Assumes: probes arrive synchronous to i_core_clk from the user design
// Notes:   level words at 0x100, branch words at 0x300 share one memory
//
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/100ps
module capture_trigger_sequencer #(
  parameter int PW = 16
) (
  input  wire logic          i_core_clk,
  input  wire logic          i_rst,
  input  wire logic [PW-1:0] i_probe_a,
  input  wire logic [PW-1:0] i_probe_b,
  input  wire logic          i_ext_trig,
  input  wire logic          i_psel,
  input  wire logic          i_penable,
  input  wire logic          i_pwrite,
  input  wire logic [11:0]   i_paddr,
  input  wire logic [31:0]   i_pwdata,
  output logic      [31:0]   o_prdata,
  output logic               o_pready,
  output logic               o_pslverr,
  output logic               o_capture_en,
  output logic               o_trigger,
  output logic               o_segment_done,
  output logic               o_acq_done
);
  localparam int NL = trig_pkg::NUM_LEVELS;
  localparam int NR = trig_pkg::NUM_RES;
  localparam int NB = trig_pkg::NUM_STATES * trig_pkg::NUM_BRANCH;
  localparam int CW = trig_pkg::CNT_W;

  // ---------------- registers ----------------
  logic [31:0] ctrl, next_ctrl;
  logic [3:0]  nlevels, next_nlevels;
  logic [NL-1:0] lvl_dis, next_lvl_dis;
  logic [15:0] post_cnt, next_post_cnt;
  logic [7:0]  nseg, next_nseg;
  logic [NR-1:0] flag_init, next_flag_init;
  logic [CW-1:0] cnt_init [NR];
  logic [CW-1:0] next_cnt_init [NR];

  logic        apb_wr, apb_rd;
  logic        in_lvl, in_br, in_cnt;
  logic        mem_we;
  logic [5:0]  mem_addr;
  logic [31:0] mem_rdata;
  logic [64*32-1:0] mem_all;
  logic        mem_rd_q, next_mem_rd_q;

  assign apb_wr  = i_psel && i_penable && i_pwrite;
  assign apb_rd  = i_psel && !i_penable && !i_pwrite;
  assign in_lvl  = i_paddr >= trig_pkg::A_LVL_BASE && i_paddr < 12'h100 + 12'h0a0;
  assign in_br   = i_paddr >= trig_pkg::A_BR_BASE && i_paddr < 12'h300 + 12'h060;
  assign in_cnt  = i_paddr >= trig_pkg::A_CNT_BASE && i_paddr < 12'h200 + 12'h050;
  // levels use slots 0..39 (4 words each); branches slots 40..63 (2 words each)
  assign mem_addr = in_br ? 6'(6'd40 + i_paddr[6:2]) : 6'(i_paddr[7:2]);
  assign mem_we   = apb_wr && (in_lvl || in_br);

  cfg_mem #(.DEPTH(64), .AW(6)) u_mem (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_we       (mem_we),
    .i_addr     (mem_addr),
    .i_wdata    (i_pwdata),
    .o_rdata    (mem_rdata),
    .o_all      (mem_all)
  );

  function automatic logic [31:0] mword(input logic [64*32-1:0] all, input int idx);
    mword = all[idx*32 +: 32];
  endfunction : mword

  // ---------------- probe history ----------------
  logic [PW-1:0] prev_a;
  logic ext_s1, ext_s2;
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      prev_a <= '0;
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
    end else begin
      prev_a <= i_probe_a; // R22
      ext_s1 <= i_ext_trig;
      ext_s2 <= ext_s1;
    end
  end

  function automatic logic pat_match(input logic [2:0] p, input logic cur, input logic prv);
    case (p)
      trig_pkg::PAT_DC:     pat_match = 1'b1;
      trig_pkg::PAT_LOW:    pat_match = !cur;
      trig_pkg::PAT_HIGH:   pat_match = cur;
      trig_pkg::PAT_FALL:   pat_match = prv && !cur;
      trig_pkg::PAT_RISE:   pat_match = !prv && cur;
      trig_pkg::PAT_EITHER: pat_match = prv ^ cur;
      default:              pat_match = 1'b1;
    endcase // R17
  endfunction : pat_match

  function automatic logic cmp(input logic [2:0] op, input logic [PW-1:0] x,
                               input logic [PW-1:0] y);
    case (op)
      trig_pkg::OP_LT: cmp = x < y;
      trig_pkg::OP_LE: cmp = x <= y;
      trig_pkg::OP_EQ: cmp = x == y;
      trig_pkg::OP_GT: cmp = x > y;
      trig_pkg::OP_GE: cmp = x >= y;
      default:         cmp = 1'b0;
    endcase // R7
  endfunction : cmp

  // level words: w0 control, w1 bus pattern value, w2 don't-care mask, w3 pattern for probe b bit 0
  logic [NL-1:0] lvl_hit;
  genvar gl;
  generate
    for (gl = 0; gl < NL; gl++) begin : g_lvl
      logic [31:0]   w0, w1, w2, w3;
      logic [PW-1:0] val, msk, bitres;
      logic          basic, adv, sig_cur, sig_prv;
      logic [3:0]    si;
      assign w0 = mword(mem_all, gl*4);
      assign w1 = mword(mem_all, gl*4 + 1);
      assign w2 = mword(mem_all, gl*4 + 2);
      assign w3 = mword(mem_all, gl*4 + 3);
      assign val = w1[PW-1:0];
      assign msk = w2[PW-1:0];
      assign si  = w0[trig_pkg::L_SIG_SEL +: 4];
      assign sig_cur = i_probe_a[si];
      assign sig_prv = prev_a[si];
      // masked bus match and single-signal pattern, all ANDed
      assign basic = (((i_probe_a ^ val) & ~msk) == '0) // R18
                  && pat_match(w0[trig_pkg::L_SIG_LSB +: 3], sig_cur, sig_prv) // R1
                  && pat_match(w3[2:0], i_probe_b[0], 1'b0);
      always_comb begin
        bitres = '0;
        adv    = 1'b0;
        case (w0[trig_pkg::L_OP_LSB +: 3])
          trig_pkg::OP_OR: begin
            bitres = i_probe_a | i_probe_b;
            adv = cmp(w0[trig_pkg::L_OP2_LSB +: 3], bitres, val); // R8
          end
          trig_pkg::OP_XOR: begin
            bitres = i_probe_a ^ i_probe_b;
            adv = cmp(w0[trig_pkg::L_OP2_LSB +: 3], bitres, val); // R8
          end
          trig_pkg::OP_EDGE: adv = pat_match(w0[trig_pkg::L_SIG_LSB +: 3],
                                             sig_cur, sig_prv); // R8
          default: adv = cmp(w0[trig_pkg::L_OP_LSB +: 3], i_probe_a, i_probe_b); // R7
        endcase
      end
      assign lvl_hit[gl] = w0[trig_pkg::L_ADV] ? adv : basic; // R2
    end
  endgenerate

  // ---------------- acquisition control ----------------
  trig_pkg::acq_state_t acq, next_acq;
  logic [3:0]    lvl_idx, next_lvl_idx;
  logic          ext_ok, next_ext_ok;
  logic          first_seg, next_first_seg;
  logic [7:0]    seg_cnt, next_seg_cnt;
  logic [15:0]   post_left, next_post_left;
  logic [1:0]    fsm_st, next_fsm_st;
  logic [NR-1:0] flags, next_flags;
  logic [CW-1:0] cnt [NR];
  logic [CW-1:0] next_cnt [NR];
  logic          trig_pulse, next_trig_pulse;
  logic          seg_pulse, next_seg_pulse;
  logic          seq_fire, st_fire;
  logic [3:0]    last_lvl;
  logic          arm_start;

  assign arm_start = apb_wr && i_paddr == trig_pkg::A_CTRL && i_pwdata[trig_pkg::C_ARM];
  assign last_lvl  = (nlevels == 4'd0) ? 4'd0 : 4'(nlevels - 4'd1);

  // sequential flow: disabled levels are skipped
  always_comb begin
    seq_fire    = 1'b0;
    next_lvl_idx = lvl_idx;
    next_ext_ok  = ext_ok || ext_s2; // R5
    if (ext_ok || !ctrl[trig_pkg::C_EXT_EN]) begin // R6
      if (!first_seg && ctrl[trig_pkg::C_SEG_EN]) begin
        seq_fire = lvl_hit[last_lvl] || lvl_dis[last_lvl]; // R4
      end else if (lvl_dis[lvl_idx] || lvl_hit[lvl_idx]) begin // R10
        if (lvl_idx >= last_lvl) seq_fire = 1'b1; // R3
        else next_lvl_idx = 4'(lvl_idx + 4'd1); // R3
      end
    end
  end

  // state-based flow: first true branch of current state wins
  logic [31:0] br_w;
  logic        br_hit;
  logic [4:0]  br_ri;
  always_comb begin
    logic [31:0] w;
    logic        c;
    w           = 32'h0000_0000;
    c           = 1'b0;
    st_fire     = 1'b0;
    next_fsm_st = fsm_st;
    next_flags  = flags;
    for (int r = 0; r < NR; r++) next_cnt[r] = cnt[r];
    br_w   = 32'h0000_0000;
    br_hit = 1'b0;
    br_ri  = 5'd0;
    for (int b = trig_pkg::NUM_BRANCH - 1; b >= 0; b--) begin // R20
      w = mword(mem_all, 40 + 2 * (int'(fsm_st) * trig_pkg::NUM_BRANCH + b));
      case (w[6:5])
        trig_pkg::CK_ALWAYS: c = 1'b1;
        trig_pkg::CK_LEVEL:  c = lvl_hit[w[3:0]];
        trig_pkg::CK_FLAG:   c = flags[w[4:0]];
        trig_pkg::CK_CNT_GE: c = cnt[w[4:0]] >= CW'(w[31:19]);
        default:             c = 1'b0;
      endcase // R11
      if (w[7] ^ c) begin
        br_hit = 1'b1;
        br_w   = w;
      end
    end
    if (br_hit) begin
      st_fire     = br_w[10]; // R12
      next_fsm_st = br_w[9:8]; // R13
      br_ri       = br_w[15:11];
      if (br_ri < 5'(NR)) begin
        case (br_w[18:16])
          trig_pkg::RA_INC: next_cnt[br_ri] = CW'(cnt[br_ri] + 1'b1); // R16
          trig_pkg::RA_DEC: next_cnt[br_ri] = CW'(cnt[br_ri] - 1'b1); // R16
          trig_pkg::RA_SET: next_flags[br_ri] = 1'b1; // R16
          trig_pkg::RA_CLR: next_flags[br_ri] = 1'b0; // R16
          default: ;
        endcase
      end
    end
  end

  // acquisition sequencing, shared by both flows
  always_comb begin
    next_acq        = acq;
    next_first_seg  = first_seg;
    next_seg_cnt    = seg_cnt;
    next_post_left  = post_left;
    next_trig_pulse = 1'b0;
    next_seg_pulse  = 1'b0;
    case (acq)
      trig_pkg::ST_IDLE: ;
      trig_pkg::ST_RUN: begin
        if (ctrl[trig_pkg::C_FLOW] ? st_fire : seq_fire) begin // R9
          next_trig_pulse = 1'b1;
          next_post_left  = post_cnt; // R15
          next_acq        = trig_pkg::ST_POST;
        end
      end
      trig_pkg::ST_POST: begin
        if (post_left != 16'h0000) next_post_left = 16'(post_left - 16'h0001); // R15
        else begin
          next_seg_pulse = 1'b1;
          next_first_seg = 1'b0;
          next_seg_cnt   = 8'(seg_cnt + 8'h01);
          // R14: a plain buffer ends with its only segment
          if (!ctrl[trig_pkg::C_SEG_EN] || 8'(seg_cnt + 8'h01) >= nseg) next_acq = trig_pkg::ST_DONE;
          else next_acq = trig_pkg::ST_RUN; // R14
        end
      end
      trig_pkg::ST_DONE: ;
      default: next_acq = trig_pkg::ST_IDLE;
    endcase
    if (arm_start) begin // R21
      next_acq       = trig_pkg::ST_RUN;
      next_first_seg = 1'b1;
      next_seg_cnt   = 8'h00;
    end else if (apb_wr && i_paddr == trig_pkg::A_CTRL && i_pwdata[trig_pkg::C_ABORT]) begin
      next_acq = trig_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      acq        <= trig_pkg::ST_IDLE;
      lvl_idx    <= 4'd0;
      ext_ok     <= 1'b0;
      first_seg  <= 1'b1;
      seg_cnt    <= 8'h00;
      post_left  <= 16'h0000;
      fsm_st     <= 2'd0;
      flags      <= '0;
      trig_pulse <= 1'b0;
      seg_pulse  <= 1'b0;
      for (int r = 0; r < NR; r++) cnt[r] <= '0;
    end else begin
      acq        <= next_acq;
      first_seg  <= next_first_seg;
      seg_cnt    <= next_seg_cnt;
      post_left  <= next_post_left;
      trig_pulse <= next_trig_pulse;
      seg_pulse  <= next_seg_pulse;
      if (arm_start) begin // R21
        lvl_idx <= 4'd0;
        ext_ok  <= 1'b0;
        fsm_st  <= 2'd0;
        flags   <= flag_init; // R19
        for (int r = 0; r < NR; r++) cnt[r] <= cnt_init[r]; // R19
      end else if (acq == trig_pkg::ST_RUN) begin
        lvl_idx <= next_lvl_idx;
        ext_ok  <= next_ext_ok;
        if (ctrl[trig_pkg::C_FLOW]) begin
          fsm_st <= next_fsm_st;
          flags  <= next_flags;
          for (int r = 0; r < NR; r++) cnt[r] <= next_cnt[r];
        end
      end
    end
  end

  // ---------------- APB registers ----------------
  always_comb begin
    next_ctrl      = ctrl;
    next_nlevels   = nlevels;
    next_lvl_dis   = lvl_dis;
    next_post_cnt  = post_cnt;
    next_nseg      = nseg;
    next_flag_init = flag_init;
    for (int r = 0; r < NR; r++) next_cnt_init[r] = cnt_init[r];
    if (apb_wr) begin
      case (i_paddr)
        trig_pkg::A_CTRL:      next_ctrl = {27'h0, 1'b0, i_pwdata[3:1], 1'b0};
        trig_pkg::A_NLEVELS:   next_nlevels = (i_pwdata[3:0] > 4'(NL)) ? 4'(NL) : i_pwdata[3:0];
        trig_pkg::A_LVL_DIS:   next_lvl_dis = i_pwdata[NL-1:0];
        trig_pkg::A_POST_CNT:  next_post_cnt = i_pwdata[15:0];
        trig_pkg::A_NSEG:      next_nseg = i_pwdata[7:0];
        trig_pkg::A_FLAG_INIT: next_flag_init = i_pwdata[NR-1:0];
        default: if (in_cnt) next_cnt_init[i_paddr[6:2]] = i_pwdata[CW-1:0];
      endcase
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl      <= 32'h0000_0000;
      nlevels   <= 4'd1;
      lvl_dis   <= '0;
      post_cnt  <= 16'h0000;
      nseg      <= 8'h01;
      flag_init <= '0;
      mem_rd_q  <= 1'b0;
      for (int r = 0; r < NR; r++) cnt_init[r] <= '0;
    end else begin
      ctrl      <= next_ctrl;
      nlevels   <= next_nlevels;
      lvl_dis   <= next_lvl_dis;
      post_cnt  <= next_post_cnt;
      nseg      <= next_nseg;
      flag_init <= next_flag_init;
      mem_rd_q  <= next_mem_rd_q;
      for (int r = 0; r < NR; r++) cnt_init[r] <= next_cnt_init[r];
    end
  end

  assign next_mem_rd_q = apb_rd && (in_lvl || in_br);

  // read data: memory words come a cycle after setup, so access phase sees them
  logic known, next_known;
  always_comb begin
    o_prdata  = 32'h0000_0000;
    next_known = 1'b1;
    case (i_paddr)
      trig_pkg::A_CTRL:      o_prdata = ctrl;
      trig_pkg::A_STATUS:    o_prdata = {16'h0, seg_cnt, 2'b00, fsm_st, lvl_idx};
      trig_pkg::A_NLEVELS:   o_prdata = {28'h0, nlevels};
      trig_pkg::A_LVL_DIS:   o_prdata = {22'h0, lvl_dis};
      trig_pkg::A_POST_CNT:  o_prdata = {16'h0, post_cnt};
      trig_pkg::A_NSEG:      o_prdata = {24'h0, nseg};
      trig_pkg::A_FLAG_INIT: o_prdata = {12'h0, flag_init};
      trig_pkg::A_FLAGS:     o_prdata = {12'h0, flags};
      trig_pkg::A_STATE:     o_prdata = {30'h0, acq};
      default: begin
        if (in_lvl || in_br) o_prdata = mem_rdata;
        else if (in_cnt) o_prdata = {16'h0, cnt[i_paddr[6:2]]};
        else next_known = 1'b0;
      end
    endcase
    known = next_known;
  end

  assign o_pready       = 1'b1;
  assign o_pslverr      = i_psel && i_penable && !known;
  assign o_capture_en   = (acq == trig_pkg::ST_RUN) || (acq == trig_pkg::ST_POST);
  assign o_trigger      = trig_pulse;
  assign o_segment_done = seg_pulse;
  assign o_acq_done     = acq == trig_pkg::ST_DONE;
endmodule : capture_trigger_sequencer

// File: test/trig_chk_props.sv
// Purpose: concurrent checks on the sequencer ports
// Assumes: one clock, apb slave answers with no wait
// Notes:   bound to every sequencer instance below
`timescale 1ns/100ps
module trig_chk (
  input wire logic        i_core_clk,
  input wire logic        i_rst,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pslverr,
  input wire logic        o_capture_en,
  input wire logic        o_trigger,
  input wire logic        o_segment_done,
  input wire logic        o_acq_done
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  logic ctl_wr;
  assign ctl_wr = i_psel && i_penable && i_pwrite && i_paddr == 12'h000;
  a_err_access: assert property (o_pslverr |-> i_psel && i_penable)
    else $error("slave error outside access");
  a_err_rdzero: assert property (o_pslverr && !i_pwrite |-> o_prdata == 32'h0)
    else $error("refused read not zero");
  a_trig_pulse: assert property (o_trigger |=> !o_trigger)
    else $error("trigger longer than one cycle");
  a_trig_in_run: assert property (o_trigger |-> $past(o_capture_en))
    else $error("trigger without running capture");
  a_seg_pulse: assert property (o_segment_done |=> !o_segment_done)
    else $error("segment done longer than one cycle");
  a_seg_after_post: assert property (o_segment_done |-> $past(o_capture_en))
    else $error("segment done without capture");
  a_done_idle: assert property (!(o_acq_done && o_capture_en))
    else $error("done while capturing");
  a_done_hold: assert property (o_acq_done && !ctl_wr |=> o_acq_done)
    else $error("done dropped without control write");
  a_arm_run: assert property (ctl_wr && i_pwdata[0] && !i_pwdata[4] |=>
    o_capture_en && !o_acq_done) else $error("arm did not start capture");
  a_abort_stop: assert property (ctl_wr && i_pwdata[4] |=>
    !o_capture_en ##1 !o_capture_en) else $error("abort did not stop capture");
  c_trig: cover property (o_trigger);
  c_seg: cover property (o_segment_done);
  c_err: cover property (o_pslverr);
endmodule : trig_chk

bind capture_trigger_sequencer trig_chk trig_chk_i (.i_core_clk, .i_rst, .i_psel,
  .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pslverr, .o_capture_en,
  .o_trigger, .o_segment_done, .o_acq_done);

// File: test/probe_model.sv
// Purpose: user logic and acquisition buffer beside the sequencer
// Assumes: probes launched from flops in the sampling clock
// Notes:   the buffer side only counts closed segments
`timescale 1ns/100ps
module probe_model (
  input  wire logic        i_core_clk,
  input  wire logic [15:0] i_a,
  input  wire logic [15:0] i_b,
  input  wire logic        i_segment_done,
  output logic      [15:0] o_probe_a,
  output logic      [15:0] o_probe_b,
  output int               o_segments
);
  initial o_segments = 0;
  always @(posedge i_core_clk) begin
    o_probe_a <= i_a;
    o_probe_b <= i_b;
    if (i_segment_done === 1'b1) o_segments <= o_segments + 1;
  end
endmodule : probe_model

// File: test/tb_top.sv
// Purpose: self-checking bench for the capture trigger sequencer
// Assumes: zero-wait apb slave, probes launched by probe_model
// Notes:   each scenario leaves capture stopped, in the done or idle state
`timescale 1ns/100ps
module tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ext = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [15:0] a_val = 16'h0;
  logic [15:0] b_val = 16'h0;
  logic [15:0] pa, pb;
  logic [31:0] prdata, rd;
  logic        pready, perr, cap_en, trig, seg_done, done, er, fired;
  int          segs, cyc, mismatches = 0, comparisons = 0;

  always #5 clk = ~clk;

  capture_trigger_sequencer #(.PW(16)) capture_trigger_sequencer_i (
    .i_core_clk(clk), .i_rst(rst), .i_probe_a(pa), .i_probe_b(pb), .i_ext_trig(ext),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(perr),
    .o_capture_en(cap_en), .o_trigger(trig), .o_segment_done(seg_done),
    .o_acq_done(done));
  probe_model probe_model_i (.i_core_clk(clk), .i_a(a_val), .i_b(b_val),
    .i_segment_done(seg_done), .o_probe_a(pa), .o_probe_b(pb), .o_segments(segs));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // entered just after an edge; one idle cycle follows every transfer
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = perr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdc
  task automatic lvl(input int l, input logic [31:0] w0, v, m, w3);
    logic [11:0] b;
    b = 12'h100 + 12'(l * 16);
    wr(b, w0);
    wr(b + 12'h004, v);
    wr(b + 12'h008, m);
    wr(b + 12'h00c, w3);
  endtask : lvl
  task automatic wt(input int n);
    fired = 1'b0;
    cyc = 0;
    while (!fired && cyc < n) begin
      @(posedge clk);
      cyc++;
      fired = (trig === 1'b1);
    end
  endtask : wt

  task automatic t_regs;
    rdc(12'h008, 32'h1);
    rdc(12'h014, 32'h1);
    rdc(12'h020, 32'h0);
    wr(12'h040, 32'h5);
    rdc(12'h040, 32'h0);
    chk(er, 1'b1);
    wr(12'h010, 32'h7);
    rdc(12'h010, 32'h7);
    wr(12'h010, 32'h0);
    $display("test regs done");
  endtask : t_regs
  task automatic t_basic;
    lvl(0, 32'h0, 32'h1234, 32'h00ff, 32'h2);
    a_val <= 16'h12ab;
    wr(12'h000, 32'h1);
    wt(6); chk(fired, 1'b0);
    b_val <= 16'h1;
    wt(6); chk(fired, 1'b1);
    a_val <= 16'h13ab;
    wr(12'h000, 32'h1);
    wt(6); chk(fired, 1'b0);
    wr(12'h000, 32'h10);
    lvl(0, 32'h0000_0340, 32'h0, 32'hffff, 32'h0);
    a_val <= 16'h0008;
    wr(12'h000, 32'h1);
    wt(6); chk(fired, 1'b0);
    a_val <= 16'h0;
    wt(4); chk(fired, 1'b0);
    a_val <= 16'h0008;
    wt(4); chk(fired, 1'b1);
    $display("test basic done");
  endtask : t_basic
  task automatic t_adv;
    a_val <= 16'h5;
    b_val <= 16'h7;
    for (int k = 0; k < 7; k++) begin
      lvl(0, 32'h8000_2000 | k, (k == 5) ? 32'h7 : 32'h2, 32'h0, 32'h0);
      wr(12'h000, 32'h1);
      wt(5); chk(fired, k < 2 || k > 4);
      wr(12'h000, 32'h10);
    end
    $display("test advanced done");
  endtask : t_adv
  task automatic t_seq;
    lvl(0, 32'h0, 32'h1, 32'h0, 32'h0);
    lvl(1, 32'h0, 32'h2, 32'h0, 32'h0);
    lvl(2, 32'h0, 32'h3, 32'h0, 32'h0);
    wr(12'h008, 32'h3);
    wr(12'h00c, 32'h2);
    a_val <= 16'h3;
    wr(12'h000, 32'h5);
    wt(6); chk(fired, 1'b0);
    ext <= 1'b1;
    wt(6); chk(fired, 1'b0);
    a_val <= 16'h1;
    wt(3); chk(fired, 1'b0);
    a_val <= 16'h3;
    wt(6); chk(fired, 1'b1);
    ext <= 1'b0;
    wr(12'h00c, 32'h0);
    $display("test sequential done");
  endtask : t_seq
  task automatic t_seg;
    int s0;
    s0 = segs;
    wr(12'h008, 32'h2);
    wr(12'h014, 32'h2);
    a_val <= 16'h2;
    wr(12'h000, 32'h9);
    wt(3); chk(fired, 1'b0);
    a_val <= 16'h3;
    wt(3); chk(fired, 1'b0);
    a_val <= 16'h1;
    wt(3); chk(fired, 1'b0);
    a_val <= 16'h3;
    wt(3); chk(fired, 1'b0);
    a_val <= 16'h2;
    wt(6); chk(fired, 1'b1);
    wt(8); chk(fired, 1'b1);
    rdc(12'h020, 32'h2);
    chk(segs - s0, 32'h2);
    wr(12'h014, 32'h1);
    wr(12'h008, 32'h1);
    $display("test segmented done");
  endtask : t_seg
  task automatic t_post;
    wr(12'h010, 32'h3);
    a_val <= 16'h1;
    wr(12'h000, 32'h1);
    wt(6); chk(fired, 1'b1);
    cyc = 0;
    while (seg_done !== 1'b1 && cyc < 20) begin
      @(posedge clk);
      cyc++;
    end
    chk(cyc, 32'h4);
    rdc(12'h020, 32'h2);
    chk({cap_en, done}, 32'h1);
    wr(12'h010, 32'h0);
    $display("test post count done");
  endtask : t_post
  task automatic t_state;
    lvl(0, 32'h0, 32'h9, 32'h0, 32'h0);
    wr(12'h300, 32'h0018_0460);
    wr(12'h308, 32'h0001_0020);
    a_val <= 16'h0;
    wr(12'h000, 32'h3);
    wt(4); chk(fired, 1'b0);
    a_val <= 16'h9;
    wt(3); chk(fired, 1'b0);
    a_val <= 16'h0;
    wt(5); chk(fired, 1'b1);
    rdc(12'h200, 32'h3);
    wr(12'h000, 32'h3);
    rdc(12'h200, 32'h0);
    wr(12'h000, 32'h10);
    $display("test state flow done");
  endtask : t_state

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict

  initial begin
    #200000;
    mismatches++;
    print_verdict();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_basic();
    t_adv();
    t_seq();
    t_seg();
    t_post();
    t_state();
    print_verdict();
  end
endmodule : tb_top
